// [rtl/pptc_top.sv]
// pptc_top: per-port detect, classify, power and fault timing, with irq line
// assumes synchronous inputs on a 10 MHz clock and a classic wishbone master
`timescale 1ns/100ps
`default_nettype none

module pptc_top #(
    parameter int unsigned P_PROBE_CYC    = pptc_pkg::PROBE_US * pptc_pkg::CYC_PER_US,
    parameter int unsigned P_CLASS_CYC    = pptc_pkg::CLASS_US * pptc_pkg::CYC_PER_US,
    parameter int unsigned P_MARK_CYC     = pptc_pkg::MARK_US * pptc_pkg::CYC_PER_US,
    parameter int unsigned P_FMARK_CYC    = pptc_pkg::FMARK_US * pptc_pkg::CYC_PER_US,
    parameter int unsigned P_FAULT_BO_CYC = pptc_pkg::FAULT_BO_US * pptc_pkg::CYC_PER_US,
    parameter int unsigned P_MID_BO_CYC   = pptc_pkg::MID_BO_US * pptc_pkg::CYC_PER_US,
    parameter int unsigned P_DROP_BO_CYC  = pptc_pkg::DROP_BO_US * pptc_pkg::CYC_PER_US,
    parameter int unsigned P_START_CYC    = pptc_pkg::START_US * pptc_pkg::CYC_PER_US,
    parameter int unsigned P_CUT_CYC      = pptc_pkg::CUT_US * pptc_pkg::CYC_PER_US,
    parameter int unsigned P_LIM_CYC      = pptc_pkg::LIM_US * pptc_pkg::CYC_PER_US,
    parameter int unsigned P_KA_CYC       = pptc_pkg::KA_US * pptc_pkg::CYC_PER_US,
    parameter int unsigned P_DROPOUT_CYC  = pptc_pkg::DROPOUT_US * pptc_pkg::CYC_PER_US,
    parameter int unsigned P_WDOG_CYC     = pptc_pkg::WDOG_US * pptc_pkg::CYC_PER_US
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic [9:2]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic        i_wb_we,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic [7:0]  i_sig_valid,
    input  wire logic [7:0]  i_overload,
    input  wire logic [7:0]  i_in_limit,
    input  wire logic [7:0]  i_port_voltage_sense,
    input  wire logic [7:0]  i_keepalive,
    input  wire logic        i_masked_shutdown_in_n,
    input  wire logic        i_bus_busy,
    input  wire logic        i_bus_stop,
    input  wire logic        i_ara_read,
    output wire logic [7:0]  o_fet_drive_n,
    output wire logic [7:0]  o_probe,
    output wire logic [7:0]  o_class,
    output logic             o_irq_n_line_o,
    output logic             o_irq_n_line_oe_n
);
    localparam int unsigned GW = pptc_pkg::GLITCH_CYC;

    logic [GW-1:0]     rst_sh_q;
    logic              rst_n_q;
    logic [GW-1:0]     msd_sh_q;
    logic              msd_act_q;
    logic [3:0]        ctrl_q;
    logic [7:0]        ena_q;
    logic [7:0]        grant_q;
    logic [7:0]        mask_q;
    logic [7:0]        evt_q;
    logic              ack_q;
    logic [31:0]       dat_q;
    pptc_pkg::pptc_tmr_t wd_q;
    logic              wd_exp_q;
    logic              pend_q;
    logic              oe_n_q;
    logic              irq_o_q;
    logic [7:0]        fault_w;
    logic [7:0]        pg_w;
    logic              wb_req;
    logic              wr;
    logic              irq_clr;

    // reset glitch filter
    // reset only takes hold after GW low samples, so short dips are ignored
    always_ff @(posedge i_ref_clk) begin
        rst_sh_q <= {rst_sh_q[GW-2:0], i_rst_n};
        rst_n_q  <= (rst_sh_q != '0);
    end

    // masked shutdown filter
    // filter length is far below the 6.5 us budget and the 3 us pulse
    always_ff @(posedge i_ref_clk) begin
        if (!rst_n_q) begin
            msd_sh_q  <= '1;
            msd_act_q <= 1'b0;
        end else begin
            msd_sh_q  <= {msd_sh_q[GW-2:0], i_masked_shutdown_in_n};
            msd_act_q <= (msd_sh_q == '0);
        end
    end

    assign wb_req = i_wb_cyc && i_wb_stb && !ack_q;
    assign wr     = wb_req && i_wb_we && i_wb_sel[0];

    always_ff @(posedge i_ref_clk) begin
        if (!rst_n_q) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_req;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!rst_n_q) begin
            dat_q <= 32'h0000_0000;
        end else if (wb_req && !i_wb_we) begin
            case (i_wb_adr)
                pptc_pkg::REG_CTRL:   dat_q <= {24'h00_0000, wd_exp_q, 3'h0, ctrl_q};
                pptc_pkg::REG_PGOOD:  dat_q <= {24'h00_0000, pg_w};
                pptc_pkg::REG_EVENT:  dat_q <= {24'h00_0000, evt_q};
                pptc_pkg::REG_ENABLE: dat_q <= {24'h00_0000, ena_q};
                pptc_pkg::REG_GRANT:  dat_q <= {24'h00_0000, grant_q};
                pptc_pkg::REG_PWRON:  dat_q <= {24'h00_0000, ~o_fet_drive_n};
                pptc_pkg::REG_SDMASK: dat_q <= {24'h00_0000, mask_q};
                default:              dat_q <= 32'h0000_0000;
            endcase
        end
    end

    assign o_wb_ack = ack_q;
    assign o_wb_dat = dat_q;

    always_ff @(posedge i_ref_clk) begin
        if (!rst_n_q) begin
            ctrl_q  <= pptc_pkg::CTRL_RST;
            ena_q   <= pptc_pkg::ENABLE_RST;
            grant_q <= pptc_pkg::GRANT_RST;
            mask_q  <= pptc_pkg::SDMASK_RST;
        end else if (wr) begin
            case (i_wb_adr)
                pptc_pkg::REG_CTRL:   ctrl_q  <= i_wb_dat[3:0];
                pptc_pkg::REG_ENABLE: ena_q   <= i_wb_dat[7:0];
                pptc_pkg::REG_GRANT:  grant_q <= i_wb_dat[7:0];
                pptc_pkg::REG_SDMASK: mask_q  <= i_wb_dat[7:0];
                default: ;
            endcase
        end
    end

    // sticky fault log
    // a new fault in the clearing cycle survives the clear
    always_ff @(posedge i_ref_clk) begin
        if (!rst_n_q) begin
            evt_q <= 8'h00;
        end else if (wr && i_wb_adr == pptc_pkg::REG_EVENT) begin
            evt_q <= (evt_q & ~i_wb_dat[7:0]) | fault_w;
        end else begin
            evt_q <= evt_q | fault_w;
        end
    end

    // bus watchdog
    // every stop condition proves the host alive and reloads the count
    always_ff @(posedge i_ref_clk) begin
        if (!rst_n_q || i_bus_stop) begin
            wd_q <= pptc_pkg::pptc_tmr_t'(P_WDOG_CYC - 1);
        end else if (wd_q != '0) begin
            wd_q <= wd_q - 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!rst_n_q || i_bus_stop || !ctrl_q[pptc_pkg::CTRL_WDEN]) begin
            wd_exp_q <= 1'b0;
        end else if (wd_q == '0) begin
            wd_exp_q <= 1'b1;
        end
    end

    assign irq_clr = i_ara_read || (wr && i_wb_adr == pptc_pkg::REG_IRQREL &&
                     (i_wb_dat[pptc_pkg::IRQREL_B0] || i_wb_dat[pptc_pkg::IRQREL_B1]));

    always_ff @(posedge i_ref_clk) begin
        if (!rst_n_q) begin
            pend_q <= 1'b0;
        end else if (|fault_w) begin
            pend_q <= 1'b1;
        end else if (irq_clr) begin
            pend_q <= 1'b0;
        end
    end

    // follows pend_q one cycle later, frozen while i_bus_busy is high
    always_ff @(posedge i_ref_clk) begin
        if (!rst_n_q) begin
            oe_n_q  <= 1'b1;
            irq_o_q <= 1'b0;
        end else begin
            irq_o_q <= 1'b0;
            if (!i_bus_busy) begin
                oe_n_q <= !pend_q;
            end
        end
    end

    assign o_irq_n_line_o    = irq_o_q;
    assign o_irq_n_line_oe_n = oe_n_q;

    for (genvar g = 0; g < pptc_pkg::NPORT; g++) begin : g_port
        pptc_pkg::pptc_state_t st_q;
        pptc_pkg::pptc_tmr_t   tmr_q;
        pptc_pkg::pptc_flt_t   flt_q;
        pptc_pkg::pptc_flt_t   flt_lim;
        pptc_pkg::pptc_ka_t    ka_q;
        pptc_pkg::pptc_drop_t  drop_q;
        logic [pptc_pkg::DUTY_SHIFT-1:0] pre_q;
        logic fet_q;
        logic probe_q;
        logic class_q;
        logic second_q;
        logic start_q;
        logic pg_q;
        logic kill;
        logic adv;
        logic fault;
        logic ka_hit;
        logic dropped;

        assign kill = !ena_q[g] || wd_exp_q || (msd_act_q && mask_q[g]);

        always_comb begin
            if (start_q) begin
                flt_lim = pptc_pkg::pptc_flt_t'(P_START_CYC - 1);
            end else if (ctrl_q[pptc_pkg::CTRL_LIMSEL] && i_in_limit[g]) begin
                flt_lim = pptc_pkg::pptc_flt_t'(P_LIM_CYC - 1);
            end else begin
                flt_lim = pptc_pkg::pptc_flt_t'(P_CUT_CYC - 1);
            end
        end

        assign adv = i_overload[g] || i_in_limit[g];
        assign fault = (st_q == pptc_pkg::ST_POWERED) && !kill && adv && (flt_q >= flt_lim);
        assign ka_hit = i_keepalive[g] && (ka_q == pptc_pkg::pptc_ka_t'(P_KA_CYC - 1));
        assign dropped = (st_q == pptc_pkg::ST_POWERED) && (drop_q == '0) && !ka_hit;

        // slow drain
        // draining at 1/16 of the fill rate caps repeated overload near 6.3 %
        always_ff @(posedge i_ref_clk) begin
            if (!rst_n_q || st_q != pptc_pkg::ST_POWERED) begin
                flt_q <= '0;
                pre_q <= '0;
            end else begin
                pre_q <= pre_q + 1'b1;
                if (adv) begin
                    flt_q <= flt_q + 1'b1;
                end else if (pre_q == '1 && flt_q != '0) begin
                    flt_q <= flt_q - 1'b1;
                end
            end
        end

        always_ff @(posedge i_ref_clk) begin
            if (!rst_n_q || !i_keepalive[g] || st_q != pptc_pkg::ST_POWERED) begin
                ka_q <= '0;
            end else if (!ka_hit) begin
                ka_q <= ka_q + 1'b1;
            end
        end

        always_ff @(posedge i_ref_clk) begin
            if (!rst_n_q || st_q != pptc_pkg::ST_POWERED || ka_hit) begin
                drop_q <= pptc_pkg::pptc_drop_t'(P_DROPOUT_CYC - 1);
            end else if (drop_q != '0) begin
                drop_q <= drop_q - 1'b1;
            end
        end

        always_ff @(posedge i_ref_clk) begin
            if (!rst_n_q) begin
                st_q     <= pptc_pkg::ST_IDLE;
                tmr_q    <= '0;
                fet_q    <= 1'b1;
                probe_q  <= 1'b0;
                class_q  <= 1'b0;
                second_q <= 1'b0;
                start_q  <= 1'b0;
            end else if (kill) begin
                st_q    <= pptc_pkg::ST_IDLE;
                fet_q   <= 1'b1;
                probe_q <= 1'b0;
                class_q <= 1'b0;
                start_q <= 1'b0;
            end else begin
                if (tmr_q != '0) begin
                    tmr_q <= tmr_q - 1'b1;
                end
                unique case (st_q)
                    pptc_pkg::ST_IDLE: begin
                        st_q    <= pptc_pkg::ST_PROBE;
                        probe_q <= 1'b1;
                        tmr_q   <= pptc_pkg::pptc_tmr_t'(P_PROBE_CYC - 1);
                    end
                    pptc_pkg::ST_PROBE: begin
                        if (tmr_q == '0) begin
                            probe_q <= 1'b0;
                            if (i_sig_valid[g]) begin
                                st_q     <= pptc_pkg::ST_CLASS;
                                class_q  <= 1'b1;
                                second_q <= 1'b0;
                                tmr_q    <= pptc_pkg::pptc_tmr_t'(P_CLASS_CYC - 1);
                            end else if (ctrl_q[pptc_pkg::CTRL_MID]) begin
                                st_q  <= pptc_pkg::ST_BACKOFF;
                                tmr_q <= pptc_pkg::pptc_tmr_t'(P_MID_BO_CYC - 1);
                            end else begin
                                st_q <= pptc_pkg::ST_IDLE;
                            end
                        end
                    end
                    pptc_pkg::ST_CLASS: begin
                        if (tmr_q == '0) begin
                            class_q <= 1'b0;
                            if (second_q) begin
                                st_q  <= pptc_pkg::ST_FMARK;
                                tmr_q <= pptc_pkg::pptc_tmr_t'(P_FMARK_CYC - 1);
                            end else begin
                                st_q  <= pptc_pkg::ST_MARK;
                                tmr_q <= pptc_pkg::pptc_tmr_t'(P_MARK_CYC - 1);
                            end
                        end
                    end
                    pptc_pkg::ST_MARK: begin
                        if (tmr_q == '0) begin
                            st_q     <= pptc_pkg::ST_CLASS;
                            class_q  <= 1'b1;
                            second_q <= 1'b1;
                            tmr_q    <= pptc_pkg::pptc_tmr_t'(P_CLASS_CYC - 1);
                        end
                    end
                    pptc_pkg::ST_FMARK: begin
                        if (tmr_q == '0) begin
                            st_q <= pptc_pkg::ST_WAITON;
                        end
                    end
                    pptc_pkg::ST_WAITON: begin
                        // autonomous or granted power on
                        // classification totals 54.6 ms, so power lands inside 60 ms
                        if (ctrl_q[pptc_pkg::CTRL_AUTO] || grant_q[g]) begin
                            st_q    <= pptc_pkg::ST_POWERED;
                            fet_q   <= 1'b0;
                            start_q <= 1'b1;
                        end
                    end
                    pptc_pkg::ST_POWERED: begin
                        if (i_port_voltage_sense[g]) begin
                            start_q <= 1'b0;
                        end
                        if (fault) begin
                            st_q    <= pptc_pkg::ST_BACKOFF;
                            fet_q   <= 1'b1;
                            start_q <= 1'b0;
                            tmr_q   <= pptc_pkg::pptc_tmr_t'(P_FAULT_BO_CYC - 1);
                        end else if (dropped) begin
                            st_q    <= pptc_pkg::ST_BACKOFF;
                            fet_q   <= 1'b1;
                            start_q <= 1'b0;
                            tmr_q   <= pptc_pkg::pptc_tmr_t'(P_DROP_BO_CYC - 1);
                        end
                    end
                    pptc_pkg::ST_BACKOFF: begin
                        if (tmr_q == '0) begin
                            st_q <= pptc_pkg::ST_IDLE;
                        end
                    end
                    default: begin
                        st_q <= pptc_pkg::ST_IDLE;
                    end
                endcase
            end
        end

        always_ff @(posedge i_ref_clk) begin
            if (!rst_n_q) begin
                pg_q <= 1'b0;
            end else begin
                pg_q <= (st_q == pptc_pkg::ST_POWERED) && i_port_voltage_sense[g];
            end
        end

        assign fault_w[g]       = fault;
        assign pg_w[g]          = pg_q;
        assign o_fet_drive_n[g] = fet_q;
        assign o_probe[g]       = probe_q;
        assign o_class[g]       = class_q;
    end
endmodule

`default_nettype wire

// [rtl/pptc_pkg.sv]
// pptc_pkg: constants, register map and types of the port timing block
// assumes a 10 MHz core clock; times are kept in their printed unit
package pptc_pkg;
    localparam int unsigned NPORT       = 8;
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned CYC_PER_US  = CLK_HZ / 1_000_000;

    // port sequencing times in microseconds (nominal unless noted)
    localparam int unsigned PROBE_US    = 220_000;
    localparam int unsigned CLASS_US    = 12_000;
    localparam int unsigned MARK_US     = 8_600;
    localparam int unsigned FMARK_US    = 22_000;
    localparam int unsigned FAULT_BO_US = 1_100_000;
    localparam int unsigned MID_BO_US   = 2_500_000;
    localparam int unsigned DROP_BO_US  = 1_300_000;
    localparam int unsigned START_US    = 59_000;
    localparam int unsigned CUT_US      = 59_000;
    localparam int unsigned LIM_US      = 12_000;
    // shortest keepalive pulse that is honoured
    localparam int unsigned KA_US       = 1_600;
    localparam int unsigned DROPOUT_US  = 350_000;
    localparam int unsigned WDOG_US     = 2_000_000;

    // glitch filter on reset and masked shutdown, least time, rounded up
    localparam int unsigned GLITCH_NS   = 1_000;
    localparam int unsigned GLITCH_CYC  = (GLITCH_NS * CYC_PER_US + 999) / 1000;
    // overcurrent timer drains one step every 2**DUTY_SHIFT cycles, if that cycle is clean
    localparam int unsigned DUTY_SHIFT  = 4;

    // register indexes; byte address is four times the index
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_PGOOD    = 8'h01;
    localparam logic [7:0] REG_EVENT    = 8'h02;
    localparam logic [7:0] REG_ENABLE   = 8'h03;
    localparam logic [7:0] REG_GRANT    = 8'h04;
    localparam logic [7:0] REG_PWRON    = 8'h05;
    localparam logic [7:0] REG_SDMASK   = 8'h17;
    localparam logic [7:0] REG_IRQREL   = 8'h1a;

    // control and irq release register fields
    localparam int unsigned CTRL_AUTO   = 0;
    localparam int unsigned CTRL_MID    = 1;
    localparam int unsigned CTRL_LIMSEL = 2;
    localparam int unsigned CTRL_WDEN   = 3;
    localparam int unsigned CTRL_WDEXP  = 7;
    localparam int unsigned IRQREL_B0   = 6;
    localparam int unsigned IRQREL_B1   = 7;

    localparam logic [3:0] CTRL_RST     = 4'h0;
    localparam logic [7:0] ENABLE_RST   = 8'h00;
    localparam logic [7:0] GRANT_RST    = 8'h00;
    localparam logic [7:0] SDMASK_RST   = 8'h00;

    typedef logic [24:0] pptc_tmr_t;
    typedef logic [19:0] pptc_flt_t;
    typedef logic [14:0] pptc_ka_t;
    typedef logic [21:0] pptc_drop_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PROBE,
        ST_CLASS,
        ST_MARK,
        ST_FMARK,
        ST_WAITON,
        ST_POWERED,
        ST_BACKOFF
    } pptc_state_t;
endpackage

// [tb/pptc_props.sv]
// pptc_props: port timing and irq checks on the top ports
// assumes port 0 is never disabled or reset while it is powered
`timescale 1ns/100ps
`default_nettype none
module pptc_props #(
    parameter int unsigned P_PROBE_CYC    = 200,
    parameter int unsigned P_CLASS_CYC    = 20,
    parameter int unsigned P_CUT_CYC      = 60,
    parameter int unsigned P_DROPOUT_CYC  = 80,
    parameter int unsigned P_FAULT_BO_CYC = 100
) (
    input wire logic       i_ref_clk,
    input wire logic       i_rst_n,
    input wire logic [7:0] i_overload,
    input wire logic [7:0] i_keepalive,
    input wire logic       i_bus_busy,
    input wire logic       i_ara_read,
    input wire logic [7:0] o_fet_drive_n,
    input wire logic [7:0] o_probe,
    input wire logic [7:0] o_class,
    input wire logic       o_irq_n_line_oe_n
);
    int unsigned pc_q = 0, cc_q = 0, oc_q = 0, kc_q = 0, rc_q = 0, gc_q = 0;
    always_ff @(posedge i_ref_clk) begin
        pc_q <= o_probe[0] ? pc_q + 1 : 0;
        cc_q <= o_class[0] ? cc_q + 1 : 0;
        oc_q <= (!o_fet_drive_n[0] && i_overload[0]) ? oc_q + 1 : 0;
        kc_q <= (!o_fet_drive_n[0] && !i_keepalive[0]) ? kc_q + 1 : 0;
        rc_q <= i_rst_n ? 0 : rc_q + 1;
    end
    // a reset drops power too, but owes no backoff
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n)
            gc_q <= 1000000;
        else if (o_fet_drive_n[0] && !$past(o_fet_drive_n[0]))
            gc_q <= 0;
        else
            gc_q <= gc_q + 1;
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    AST_PROBE_LEN: assert property ($fell(o_probe[0]) |-> pc_q == P_PROBE_CYC)
        else $error("probe phase length wrong");
    AST_CLASS_LEN: assert property ($fell(o_class[0]) |-> cc_q == P_CLASS_CYC)
        else $error("class pulse length wrong");
    AST_OVERLOAD_CUT: assert property (oc_q <= P_CUT_CYC + 2)
        else $error("overcurrent held too long");
    AST_DROPOUT_CUT: assert property (kc_q <= P_DROPOUT_CYC + 2)
        else $error("power kept without keepalive");
    AST_BACKOFF: assert property ($rose(o_probe[0]) |-> gc_q >= P_FAULT_BO_CYC)
        else $error("probe restarted too soon");
    AST_ARA_RELEASE: assert property (i_ara_read && !i_bus_busy |-> ##[1:15] o_irq_n_line_oe_n)
        else $error("irq not released");
    AST_IRQ_FROZEN: assert property ($changed(o_irq_n_line_oe_n) |-> !$past(i_bus_busy))
        else $error("irq moved during transaction");
    AST_RESET_OFF: assert property (disable iff (1'h0) rc_q >= 12 |->
        o_fet_drive_n == 8'hff && o_probe == 8'h00 && o_class == 8'h00 && o_irq_n_line_oe_n)
        else $error("outputs active in reset");
endmodule
bind pptc_top pptc_props #(.P_PROBE_CYC(P_PROBE_CYC), .P_CLASS_CYC(P_CLASS_CYC),
    .P_CUT_CYC(P_CUT_CYC), .P_DROPOUT_CYC(P_DROPOUT_CYC), .P_FAULT_BO_CYC(P_FAULT_BO_CYC))
    pptc_props_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_overload(i_overload),
    .i_keepalive(i_keepalive), .i_bus_busy(i_bus_busy), .i_ara_read(i_ara_read),
    .o_fet_drive_n(o_fet_drive_n), .o_probe(o_probe), .o_class(o_class),
    .o_irq_n_line_oe_n(o_irq_n_line_oe_n));
`default_nettype wire

// [tb/pptc_pd_model.sv]
// pptc_pd_model: powered devices on the eight ports
// assumes the bench picks which ports carry a signature, a load or a short
`timescale 1ns/100ps
`default_nettype none
module pptc_pd_model (
    input  wire logic       i_ref_clk,
    input  wire logic [7:0] i_fet_drive_n,
    input  wire logic [7:0] i_probe,
    input  wire logic [7:0] i_present,
    input  wire logic [7:0] i_load,
    input  wire logic [7:0] i_short,
    output logic      [7:0] o_sig_valid,
    output logic      [7:0] o_pgood,
    output logic      [7:0] o_keepalive,
    output logic      [7:0] o_overload
);
    logic [7:0] noise_q = 8'h5a;
    always_ff @(posedge i_ref_clk) begin
        noise_q <= ~noise_q;
        // outside a probe the signature is meaningless, so it churns
        o_sig_valid <= (i_probe & i_present) | (~i_probe & noise_q);
        o_pgood <= ~i_fet_drive_n;
        o_keepalive <= ~i_fet_drive_n & i_load;
        o_overload <= ~i_fet_drive_n & i_short;
    end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// testbench: registers, port sequencing, faults, irq and masked shutdown
// assumes shortened counts; serial bus busy, stop and alert reads come from here
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk = 0, rst_n = 0, we = 0, cyc = 0, stb = 0, busy = 0, stop = 0, ara = 0;
    logic        msd_n = 1, ack, oe_n, irq_o;
    logic [3:0]  sel = 4'hf;
    logic [7:0]  adr = 8'h00, present = 8'h00, load = 8'h00, short = 8'h00, lim = 8'h00, r;
    logic [7:0]  fet_n, probe, cls, sig, pg, ka, ov, eq[$];
    logic [7:0]  regs[9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h17, 8'h1a, 8'h40};
    logic [7:0]  rel[2] = '{8'h40, 8'h80};
    logic [31:0] wdat = 32'h0, rdat;
    int          fail_count = 0, check_count = 0;
    string       nq[$];
    localparam int unsigned PRB = 200, CLS = 20, MRK = 15, FMK = 30, FBO = 100, DBO = 120;
    localparam int unsigned STRT = 60, CUT = 60, KAW = 8, DRP = 80, LIM = 20;
    pptc_top #(.P_PROBE_CYC(PRB), .P_CLASS_CYC(CLS), .P_MARK_CYC(MRK), .P_FMARK_CYC(FMK),
        .P_FAULT_BO_CYC(FBO), .P_DROP_BO_CYC(DBO), .P_START_CYC(STRT), .P_CUT_CYC(CUT),
        .P_LIM_CYC(LIM), .P_KA_CYC(KAW), .P_DROPOUT_CYC(DRP)) pptc_top_inst (.i_ref_clk(clk),
        .i_rst_n(rst_n), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .i_wb_we(we),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_dat(rdat), .o_wb_ack(ack), .i_sig_valid(sig),
        .i_overload(ov), .i_in_limit(lim), .i_port_voltage_sense(pg), .i_keepalive(ka),
        .i_masked_shutdown_in_n(msd_n), .i_bus_busy(busy), .i_bus_stop(stop),
        .i_ara_read(ara), .o_fet_drive_n(fet_n), .o_probe(probe), .o_class(cls),
        .o_irq_n_line_o(irq_o), .o_irq_n_line_oe_n(oe_n));
    pptc_pd_model pptc_pd_model_inst (.i_ref_clk(clk), .i_fet_drive_n(fet_n), .i_probe(probe),
        .i_present(present), .i_load(load), .i_short(short), .o_sig_valid(sig),
        .o_pgood(pg), .o_keepalive(ka), .o_overload(ov));
    initial forever #50 clk = ~clk;
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        adr <= a;
        we <= w;
        wdat <= {24'h000000, d};
        cyc <= 1'h1;
        stb <= 1'h1;
        do begin
            @(posedge clk);
        end while (ack !== 1'h1);
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        eq.push_back(e);
        nq.push_back(n);
        wb(a, 1'h0, 8'h00);
    endtask
    task automatic wait_fet(input logic [7:0] m, input logic [7:0] v);
        int n;
        n = 0;
        while ((fet_n & m) !== v && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) begin
            fail_count++;
            tally_and_finish();
        end
    endtask
    // read data is judged where the answer appears, in request order
    always @(posedge clk) if (ack === 1'h1 && !we) begin
        check(nq.pop_front(), {24'h000000, eq.pop_front()}, rdat);
    end
    initial begin
        #2_000_000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        int n;
        r = 8'($urandom(35));
        repeat (45) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        wb(8'h40, 1'h1, 8'hff);
        foreach (regs[i]) rd(regs[i], 8'h00, "reset value");
        $display("test reset values done");
        present <= 8'h05;
        load <= 8'h05;
        wb(8'h00, 1'h1, 8'h01);
        wb(8'h03, 1'h1, 8'h07);
        wait_fet(8'h05, 8'h00);
        rd(8'h05, 8'h05, "powered ports");
        rd(8'h01, 8'h05, "power good");
        $display("test power up done");
        busy <= 1'h1;
        short <= 8'h01;
        wait_fet(8'h01, 8'h01);
        short <= 8'h00;
        repeat (3) @(posedge clk);
        check("irq while busy", 1'h1, oe_n);
        busy <= 1'h0;
        stop <= 1'h1;
        @(posedge clk);
        stop <= 1'h0;
        repeat (15) @(posedge clk);
        check("irq after stop", 1'h0, oe_n);
        check("irq level", 1'h0, irq_o);
        rd(8'h02, 8'h01, "fault event");
        ara <= 1'h1;
        @(posedge clk);
        ara <= 1'h0;
        repeat (4) @(posedge clk);
        check("irq after alert read", 1'h1, oe_n);
        foreach (rel[i]) begin
            wait_fet(8'h01, 8'h00);
            short <= 8'h01;
            wait_fet(8'h01, 8'h01);
            short <= 8'h00;
            repeat (2) @(posedge clk);
            check("irq on fault", 1'h0, oe_n);
            wb(8'h1a, 1'h1, rel[i]);
            repeat (3) @(posedge clk);
            check("irq on release", 1'h1, oe_n);
            wb(8'h02, 1'h1, 8'h01);
            rd(8'h02, 8'h00, "event cleared");
        end
        $display("test faults and irq done");
        wait_fet(8'h01, 8'h00);
        load <= 8'h04;
        wait_fet(8'h01, 8'h01);
        rd(8'h05, 8'h04, "after dropout");
        rd(8'h02, 8'h00, "no fault on dropout");
        load <= 8'h05;
        $display("test keepalive dropout done");
        wait_fet(8'h05, 8'h00);
        r = (8'($urandom()) & 8'hfa) | 8'h04;
        wb(8'h17, 1'h1, r);
        sel <= 4'he;
        wb(8'h17, 1'h1, ~r);
        sel <= 4'hf;
        rd(8'h17, r, "shutdown mask");
        msd_n <= 1'h0;
        repeat (30) @(posedge clk);
        msd_n <= 1'h1;
        rd(8'h05, 8'h01, "masked shutdown");
        $display("test masked shutdown done");
        wb(8'h00, 1'h1, 8'h05);
        lim <= 8'h01;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (fet_n[0] !== 1'h1 && n < 200);
        lim <= 8'h00;
        check("limit window", LIM + 1, n);
        rd(8'h02, 8'h01, "limit fault");
        $display("test limit window done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
